// ===== src/isx_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "isx_cfg.svh"

module isx_exec (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               en_i,
  input  wire isx_pkg::isx_issue_t issue_i,
  output logic                    busy_o,
  output logic [7:0]              acc_o,
  output logic                    zero_o,
  output isx_pkg::isx_fwr_t       fwr_o,
  output logic                    skip_o,
  output logic                    done_o
);
  import isx_pkg::*;

  isx_regs_t  st_r;
  isx_regs_t  st_nxt;
  isx_dec_t   dec;
  logic [7:0] inc_res;
  logic [7:0] or_res;
  logic [7:0] res;
  logic       take;

  // Opcode decode of the issued word
  isx_decode u_dec (
    .word_i (issue_i.word),
    .dec_o  (dec)
  );

  // Datapath: 8-bit sum drops the carry, so 0xFF wraps to 0x00
  assign inc_res = 8'(issue_i.file_data + 8'h01);
  assign or_res  = st_r.acc | issue_i.file_data;

  // A skip cycle swallows whatever word the sequencer offers
  assign take = issue_i.valid && (st_r.st == ISX_ST_RUN);

  // Next state of the whole unit
  always_comb begin
    st_nxt      = st_r;
    st_nxt.fwr.we = 1'h0;
    st_nxt.skip = 1'h0;
    st_nxt.done = 1'h0;
    res         = 8'h00;
    unique case (st_r.st)
      ISX_ST_RUN: begin
        if (take && dec.op != ISX_OP_NONE) begin
          res = (dec.op == ISX_OP_INCSKIP) ? inc_res : or_res;
          st_nxt.done = 1'h1;
          // Result routing by the destination bit
          if (dec.dest == `ISX_DEST_ACC) begin
            st_nxt.acc = res;
          end else begin
            st_nxt.fwr.we   = 1'h1;
            st_nxt.fwr.addr = dec.addr;
            st_nxt.fwr.data = res;
          end
          if (dec.op == ISX_OP_ORWF) begin
            st_nxt.zero = (or_res == 8'h00);
          end else if (inc_res == 8'h00) begin
            // Fetched word is dropped; spend a no-op cycle
            st_nxt.skip = 1'h1;
            st_nxt.st   = ISX_ST_SKIP;
          end
        end
      end
      ISX_ST_SKIP: begin
        // No-op cycle; zero flag and accumulator untouched, skip and done flags cleared
        st_nxt.st = ISX_ST_RUN;
      end
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r.st   <= ISX_ST_RUN;
      st_r.acc  <= `ISX_ACC_RST;
      st_r.zero <= `ISX_ZERO_RST;
      st_r.fwr  <= '0;
      st_r.skip <= 1'h0;
      st_r.done <= 1'h0;
    end else if (en_i) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign busy_o = (st_r.st == ISX_ST_SKIP);
  assign acc_o  = st_r.acc;
  assign zero_o = st_r.zero;
  assign fwr_o  = st_r.fwr;
  assign skip_o = st_r.skip;
  assign done_o = st_r.done;

endmodule : isx_exec
`default_nettype wire

// ===== src/isx_cfg.svh
`ifndef ISX_CFG_SVH
`define ISX_CFG_SVH

// Instruction word layout
`define ISX_IW_W        14
`define ISX_OPC_MSB     13
`define ISX_OPC_LSB     8
`define ISX_DEST_BIT    7
`define ISX_ADDR_MSB    6
`define ISX_ADDR_LSB    0

// Opcode fields (top six bits)
`define ISX_OPC_INCSKIP 6'h0F
`define ISX_OPC_ORWF    6'h04

// Destination bit values
`define ISX_DEST_ACC    1'h0
`define ISX_DEST_FILE   1'h1

// Reset values
`define ISX_ACC_RST     8'h00
`define ISX_ZERO_RST    1'h0

`endif

// ===== src/isx_pkg.sv
package isx_pkg;

  // Decoded operation
  typedef enum logic [1:0] {
    ISX_OP_NONE,
    ISX_OP_INCSKIP,
    ISX_OP_ORWF
  } isx_op_t;

  // Instruction issued by the sequencer with the file operand it fetched
  typedef struct packed {
    logic       valid;
    logic [13:0] word;
    logic [7:0]  file_data;
  } isx_issue_t;

  // File register write-back request
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } isx_fwr_t;

  // Decoder result
  typedef struct packed {
    isx_op_t    op;
    logic       dest;
    logic [6:0] addr;
  } isx_dec_t;

  // Execution state phases
  typedef enum logic {
    ISX_ST_RUN,
    ISX_ST_SKIP
  } isx_state_t;

  // Whole state of the execution unit
  typedef struct packed {
    isx_state_t st;
    logic [7:0] acc;
    logic       zero;
    isx_fwr_t   fwr;
    logic       skip;
    logic       done;
  } isx_regs_t;

endpackage : isx_pkg

// ===== src/isx_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "isx_cfg.svh"

module isx_decode (
  input  wire logic [13:0]    word_i,
  output isx_pkg::isx_dec_t   dec_o
);
  import isx_pkg::*;

  logic [5:0] opc;

  // Split the word into opcode, destination and file address
  assign opc = word_i[`ISX_OPC_MSB:`ISX_OPC_LSB];

  // Opcode match; anything else is not ours
  always_comb begin
    dec_o.dest = word_i[`ISX_DEST_BIT];
    dec_o.addr = word_i[`ISX_ADDR_MSB:`ISX_ADDR_LSB];
    if (opc == `ISX_OPC_INCSKIP) begin
      dec_o.op = ISX_OP_INCSKIP;
    end else if (opc == `ISX_OPC_ORWF) begin
      dec_o.op = ISX_OP_ORWF;
    end else begin
      dec_o.op = ISX_OP_NONE;
    end
  end

endmodule : isx_decode
`default_nettype wire

// ===== dv/isx_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module isx_exec_asserts (
  input wire logic                clk_i,
  input wire logic                nrst_i,
  input wire logic                en_i,
  input wire isx_pkg::isx_issue_t issue_i,
  input wire logic                busy_o,
  input wire logic [7:0]          acc_o,
  input wire logic                zero_o,
  input wire isx_pkg::isx_fwr_t   fwr_o,
  input wire logic                skip_o,
  input wire logic                done_o
);
  // Taken issue and both candidate results
  wire inc = en_i && issue_i.valid && !busy_o && issue_i.word[13:8] == 6'h0F;
  wire orr = en_i && issue_i.valid && !busy_o && issue_i.word[13:8] == 6'h04;
  wire d = issue_i.word[7];
  wire [7:0] n = issue_i.file_data + 8'h01;
  wire [7:0] o = acc_o | issue_i.file_data;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  inc_flag_a: assert property (inc |=> done_o && $stable(zero_o))
    else $error("inc flag");
  inc_file_a: assert property (inc && d |=> fwr_o.data == $past(n))
    else $error("inc file");
  inc_acc_a: assert property (inc && !d |=> acc_o == $past(n))
    else $error("inc acc");
  skip_flag_a: assert property (inc |=> busy_o == skip_o &&
    skip_o == !$past(n)) else $error("skip");
  skip_end_a: assert property (skip_o && en_i |=> !busy_o)
    else $error("busy");
  or_acc_a: assert property (orr && !d |=> acc_o == $past(o) &&
    zero_o == !acc_o) else $error("or acc");
  or_file_a: assert property (orr && d |=> fwr_o.we &&
    fwr_o.data == $past(o) && zero_o == !fwr_o.data) else $error("or file");
  // Wrap with skip, OR into file
  cover property (inc && n == 8'h00);
  cover property (orr && d);
  cover property (skip_o);
endmodule : isx_exec_asserts
bind isx_exec isx_exec_asserts i_chk (.*);
`default_nettype wire

// ===== dv/isx_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t mismatch", $time); end end
module isx_exec_tb_top;
  import isx_pkg::*;
  logic clk_i = 0, nrst_i = 0, en_i = 0, z = 0, b = 0;
  logic busy_o, zero_o, skip_o, done_o;
  logic [7:0] acc_o, a = 0, fd = 0, r, f;
  logic [6:0] fa = 0;
  logic e = 1;
  logic [13:0] w;
  logic [26:0] q[$];
  isx_issue_t issue_i = '0;
  isx_fwr_t fwr_o;
  int err_count = 0, compares = 0;
  wire [26:0] res = {acc_o, zero_o, fwr_o.we, fwr_o.addr, fwr_o.data,
                     skip_o, busy_o};
  isx_exec i_dut (.*);
  // 4 ns period
  always #2 clk_i = ~clk_i;
  task report_and_stop;
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Oldest note per executed instruction
  // A frozen pulse is counted once, at the enabled edge
  always @(posedge clk_i) if (done_o === 1'b1 && en_i === 1'b1)
    `CHK(res, q.pop_front())
  initial begin
    void'($urandom(1));
    repeat (4) @(posedge clk_i);
    nrst_i <= 1;
    en_i <= 1;
    // Back-to-back mix; the word after a wrap must be lost
    for (int i = 0; i < 300; i++) begin
      w = {6'(i % 3 ? i % 3 == 1 ? 15 : $urandom : 4), 8'($urandom)};
      f = i ? ($urandom % 3 ? 8'($urandom) : 8'hFF) : 8'h00;
      e = ($urandom % 8) != 0;
      @(posedge clk_i);
      issue_i <= '{1'b1, w, f};
      en_i <= e;
      r = w[13:8] == 6'h0F ? f + 8'h01 : a | f;
      // Enable low: word not taken, skip state frozen
      if (e && (b || !(w[13:8] inside {6'h0F, 6'h04}))) b = 0;
      else if (e) begin
        z = w[13:8] == 6'h04 ? r == 0 : z;
        if (w[7]) begin
          fd = r;
          fa = w[6:0];
        end else a = r;
        b = w[13:8] == 6'h0F && r == 0;
        q.push_back({a, z, w[7], fa, fd, b, b});
      end
    end
    @(posedge clk_i);
    issue_i.valid <= 0;
    en_i <= 1;
    repeat (3) @(posedge clk_i);
    `CHK(q.size(), 0)
    report_and_stop;
  end
  // Some 300 cycles expected, wide margin
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    report_and_stop;
  end
endmodule : isx_exec_tb_top
`default_nettype wire
